// ---- design/cfg_regs_pkg.sv ----
package cfg_regs_pkg;

   // Widths of the register port and of an I2C target address.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int I2C_W  = 7;

   // Register offsets on the local and remote register ports.
   localparam logic [7:0] OFS_ALIAS7  = 8'h17;
   localparam logic [7:0] OFS_BOX_A   = 8'h18;
   localparam logic [7:0] OFS_BOX_B   = 8'h19;
   localparam logic [7:0] OFS_PIN_CFG = 8'h1A;

   // Reset values of the four registers.
   localparam logic [7:0] RST_ALIAS7  = 8'h00;
   localparam logic [7:0] RST_BOX_A   = 8'h00;
   localparam logic [7:0] RST_BOX_B   = 8'h01;
   localparam logic [7:0] RST_PIN_CFG = 8'h00;

   // Answer to a read of an offset outside this slice.
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // Alias field sits in bits 7 to 1; bit 0 is reserved.
   localparam int ALIAS_LSB = 1;
   localparam int ALIAS_MSB = 7;

   // Writable bits of the alias and pin configuration registers; reserved bits are zero here.
   localparam logic [7:0] MASK_ALIAS7  = 8'hFE;
   localparam logic [7:0] MASK_PIN_CFG = 8'hBB;

   // Field positions of the pin configuration register.
   localparam int GLB_LEVEL_BIT = 7;
   localparam int GLB_DIR_BIT   = 5;
   localparam int GLB_EN_BIT    = 4;
   localparam int P9_LEVEL_BIT  = 3;
   localparam int P9_DIR_BIT    = 1;
   localparam int P9_EN_BIT     = 0;

   // Encodings of the {direction, enable} pair.
   localparam logic [1:0] PAIR_FUNC = 2'h0;
   localparam logic [1:0] PAIR_OUT  = 2'h1;
   localparam logic [1:0] PAIR_HIZ  = 2'h2;
   localparam logic [1:0] PAIR_IN   = 2'h3;

   // Pad behaviour selected by a direction and enable pair.
   typedef enum logic [1:0] {
      MODE_FUNC,
      MODE_OUT,
      MODE_HIZ,
      MODE_IN
   } pad_mode_t;

endpackage

// ---- design/pad_mode_decode.sv ----
// Turns a {direction, enable} pair into a pad behaviour.
module pad_mode_decode
   import cfg_regs_pkg::*;
(
   input  wire logic                    dir_in,
   input  wire logic                    en_in,
   output cfg_regs_pkg::pad_mode_t      mode_out
);

   // Pure decode; the caller registers anything that reaches a pin.
   always_comb begin
      case ({dir_in, en_in})
         PAIR_FUNC: mode_out = MODE_FUNC;
         PAIR_HIZ:  mode_out = MODE_HIZ;
         PAIR_OUT:  mode_out = MODE_OUT;
         PAIR_IN:   mode_out = MODE_IN;
         default:   mode_out = MODE_FUNC;
      endcase
   end

endmodule // pad_mode_decode

// ---- design/alias_match_unit.sv ----
// Compares a local I2C target address against one alias slot.
module alias_match_unit
   import cfg_regs_pkg::*;
(
   input  wire logic [I2C_W-1:0]        addr_in,
   input  wire logic                    start_in,
   input  wire logic [I2C_W-1:0]        alias_in,
   output logic                         hit_out
);

   // An empty slot never matches, even an address of zero.
   assign hit_out = start_in && (alias_in != '0) &&
                    (addr_in == alias_in);

endmodule // alias_match_unit

// ---- design/alias_mailbox_gpio_cfg_regs.sv ----
// Operation
// - Alias seven in bits 7-1 selects remote target.
// - Matching transaction forwarded with remote target address.
// - Alias value zero disables that slot entirely.
// - First mailbox byte, read/write, resets to zero.
// - Second mailbox byte, read/write, resets to one.
// - Mailboxes reachable by local and remote controllers.
// - Bit 7 drives non-GPIO pins under global output.
// - Global direction/enable pair selects forced pad behaviour.
// - Pin's own configuration overrides the global force.
// - Bit 3 drives pin nine in local GPIO output.
// - Pin nine direction/enable pair selects its pad mode.
// - Pin configuration register resets to all zeros.
//
// The plain strobed port was decided locally.
module alias_mailbox_gpio_cfg_regs
   import cfg_regs_pkg::*;
(
   input  wire logic                        clk_in,
   input  wire logic                        nrst_in,
   // Local register port.
   input  wire logic [ADDR_W-1:0]           addr_in,
   input  wire logic [DATA_W-1:0]           wdata_in,
   input  wire logic                        wr_in,
   input  wire logic                        rd_in,
   output logic [DATA_W-1:0]                rdata_out,
   // Register port driven by the controller across the link.
   input  wire logic [ADDR_W-1:0]           rmt_addr_in,
   input  wire logic [DATA_W-1:0]           rmt_wdata_in,
   input  wire logic                        rmt_wr_in,
   input  wire logic                        rmt_rd_in,
   output logic [DATA_W-1:0]                rmt_rdata_out,
   // Local I2C address decoder.
   input  wire logic [cfg_regs_pkg::I2C_W-1:0] i2c_addr_in,
   input  wire logic                        i2c_start_in,
   input  wire logic [cfg_regs_pkg::I2C_W-1:0] remote_target_id_in,
   output logic                             fwd_valid_out,
   output logic [cfg_regs_pkg::I2C_W-1:0]   fwd_addr_out,
   output logic [cfg_regs_pkg::I2C_W-1:0]   remote_alias_seven_out,
   // Pin nine pad and its sources.
   input  wire logic                        pin_nine_pad_in,
   input  wire logic                        pin_nine_func_level_in,
   input  wire logic                        pin_nine_remote_ctl_in,
   input  wire logic                        pin_nine_remote_level_in,
   output logic                             pin_nine_pad_out,
   output logic                             pin_nine_pad_oe_out,
   output logic                             pin_nine_in_level_out,
   // Global force applied to pins not individually configured.
   output logic                             glb_force_level_out,
   output logic                             glb_force_oe_out,
   output logic                             glb_force_in_out,
   output logic                             glb_tristate_out
);

   import cfg_regs_pkg::*;

   // Every flip-flop of the block lives in this one record.
   // A read and a write to one offset in the same cycle return the
   // old value, since the answer is built from the present state.
   typedef struct packed {
      logic [I2C_W-1:0]  alias7;      // Alias seven field.
      logic [DATA_W-1:0] box_a;       // First mailbox byte.
      logic [DATA_W-1:0] box_b;       // Second mailbox byte.
      logic [DATA_W-1:0] pin_cfg;     // Global and pin nine config.
      logic [DATA_W-1:0] rdata;       // Local read answer.
      logic [DATA_W-1:0] rmt_rdata;   // Remote read answer.
      logic              fwd_valid;   // Forward request pulse.
      logic [I2C_W-1:0]  fwd_addr;    // Remapped target address.
      logic              pad_level;   // Level driven on pin nine.
      logic              pad_oe;      // Pin nine driven when high.
      logic              pad_in;      // Sampled pin nine level.
      logic              glb_level;   // Global forced level.
      logic              glb_oe;      // Global forced output.
      logic              glb_in;      // Global forced input.
      logic              glb_hiz;     // Global tri-state.
   } state_t;

   // Present and next state.
   // The next state is complete every cycle, so no latch forms.
   state_t st_r;
   state_t st_nxt;

   // Alias compare result for the current cycle.
   // Only the forward pulse and forward address built from it are registered.
   logic      alias_hit;

   // Decoded pad behaviour of the global pair and of pin nine.
   pad_mode_t glb_mode;
   pad_mode_t pin_mode;

   // Pin nine after the per-pin versus global priority is applied.
   // The other pins apply the global flags with their own
   // configuration, outside this block.
   pad_mode_t eff_mode;

   // Which source the effective mode came from.
   // High when pin nine's own pair is not 00.
   logic      pin_owns;

   // Register read value, shared by both read ports.
   // Both ports see one image of the bank, so either end of the link
   // reads back what the other end left in a mailbox.
   // Unmapped offsets answer zero; the port has no error signal.
   function automatic logic [DATA_W-1:0] reg_read(
      input state_t          s,
      input logic [ADDR_W-1:0] a
   );
      logic [DATA_W-1:0] v;
      v = RD_UNMAPPED;
      case (a)
         // Reserved bit 0 of the alias slot reads as zero.
         OFS_ALIAS7:  v = {s.alias7, 1'b0};
         OFS_BOX_A:   v = s.box_a;
         OFS_BOX_B:   v = s.box_b;
         // Stored already masked, so reserved bits read zero.
         OFS_PIN_CFG: v = s.pin_cfg;
         default:     v = RD_UNMAPPED;
      endcase
      return v;
   endfunction

   // The alias compare is a leaf so the other slots can reuse it.
   alias_match_unit u_alias7 (
      .addr_in  (i2c_addr_in),
      .start_in (i2c_start_in),
      .alias_in (st_r.alias7),
      .hit_out  (alias_hit)
   );

   // Global force pair, bits 5 and 4.
   pad_mode_decode u_glb_mode (
      .dir_in   (st_r.pin_cfg[GLB_DIR_BIT]),
      .en_in    (st_r.pin_cfg[GLB_EN_BIT]),
      .mode_out (glb_mode)
   );

   // Pin nine pair, bits 1 and 0.
   pad_mode_decode u_pin_mode (
      .dir_in   (st_r.pin_cfg[P9_DIR_BIT]),
      .en_in    (st_r.pin_cfg[P9_EN_BIT]),
      .mode_out (pin_mode)
   );

   // Per-pin settings win once the pin leaves functional mode.
   // A pin left at 00 is not individually configured, so the global
   // force decides for it.
   always_comb begin
      pin_owns = (pin_mode != MODE_FUNC);
      if (pin_owns) begin
         eff_mode = pin_mode;
      end else begin
         eff_mode = glb_mode;
      end
   end

   // Next-state logic for the whole block.
   always_comb begin
      st_nxt = st_r;

      // Read answers stand for one cycle only, zero otherwise.
      // A zero between reads keeps a stale byte from passing for a
      // fresh answer.
      st_nxt.rdata     = '0;
      st_nxt.rmt_rdata = '0;
      if (rd_in) begin
         st_nxt.rdata = reg_read(st_r, addr_in);
      end
      if (rmt_rd_in) begin
         st_nxt.rmt_rdata = reg_read(st_r, rmt_addr_in);
      end

      // Remote writes reach the mailboxes and the rest of the map.
      // The local write is applied after it, so when both sides hit
      // the same register in one cycle the local controller wins.
      if (rmt_wr_in) begin
         case (rmt_addr_in)
            OFS_ALIAS7: begin
               // Reserved bit 0 is dropped on this port too.
               st_nxt.alias7 = rmt_wdata_in[ALIAS_MSB:ALIAS_LSB];
            end
            OFS_BOX_A: begin
               st_nxt.box_a = rmt_wdata_in;
            end
            OFS_BOX_B: begin
               st_nxt.box_b = rmt_wdata_in;
            end
            OFS_PIN_CFG: begin
               // Reserved bits are masked on this port too.
               st_nxt.pin_cfg = rmt_wdata_in & MASK_PIN_CFG;
            end
            default: begin
               // Unmapped offsets are ignored.
            end
         endcase
      end

      // Local writes.
      // Writes never stall; the new value is there for a read
      // strobed in the next cycle.
      if (wr_in) begin
         case (addr_in)
            OFS_ALIAS7: begin
               // Bit 0 of the write is dropped.
               st_nxt.alias7 = wdata_in[ALIAS_MSB:ALIAS_LSB];
            end
            OFS_BOX_A: begin
               // Pure storage; nothing in hardware reads it.
               st_nxt.box_a = wdata_in;
            end
            OFS_BOX_B: begin
               // Pure storage; nothing in hardware reads it.
               st_nxt.box_b = wdata_in;
            end
            OFS_PIN_CFG: begin
               // Bits 6 and 2 never store a one.
               st_nxt.pin_cfg = wdata_in & MASK_PIN_CFG;
            end
            default: begin
               // Unmapped offsets are ignored.
            end
         endcase
      end

      // Alias decode: one forward pulse per matching start.
      // A zero slot is refused inside the compare, so clearing the
      // alias stops forwarding from the next start on.
      // The compare uses the slot as it stood before this cycle's
      // write, which keeps a half-updated alias out of the decode.
      st_nxt.fwd_valid = alias_hit;
      if (alias_hit) begin
         // Address swapped for the remote target identifier.
         st_nxt.fwd_addr = remote_target_id_in;
      end

      // Global force outputs for the pins outside this block.
      // The oe, in and tri-state flags are exclusive: each comes from one mode, and all
      // start cleared every cycle.
      st_nxt.glb_level = 1'b0;
      st_nxt.glb_oe    = 1'b0;
      st_nxt.glb_in    = 1'b0;
      st_nxt.glb_hiz   = 1'b0;
      case (glb_mode)
         MODE_OUT: begin
            // Forced output carries the global level.
            st_nxt.glb_oe    = 1'b1;
            st_nxt.glb_level = st_r.pin_cfg[GLB_LEVEL_BIT];
         end
         MODE_IN: begin
            st_nxt.glb_in = 1'b1;
         end
         MODE_HIZ: begin
            st_nxt.glb_hiz = 1'b1;
         end
         MODE_FUNC: begin
            // Functional output; the pins keep their own function.
         end
         default: begin
            // Unreachable with a two-bit mode; kept as a safe default.
            st_nxt.glb_hiz = 1'b0;
         end
      endcase

      // Pin nine pad.
      // The pad is sampled in every mode; software only trusts it
      // while the pin is an input.
      // Pin inputs are taken as already synchronous, so no extra
      // synchroniser delay is added.
      st_nxt.pad_in = pin_nine_pad_in;
      case (eff_mode)
         MODE_FUNC: begin
            // Functional mode drives the pin's own function.
            st_nxt.pad_oe    = 1'b1;
            st_nxt.pad_level = pin_nine_func_level_in;
         end
         MODE_HIZ: begin
            st_nxt.pad_oe    = 1'b0;
            st_nxt.pad_level = 1'b0;
         end
         MODE_OUT: begin
            // Output drive; the level source depends on who owns it.
            st_nxt.pad_oe = 1'b1;
            if (!pin_owns) begin
               // Globally forced output uses the global level.
               st_nxt.pad_level = st_r.pin_cfg[GLB_LEVEL_BIT];
            end else if (pin_nine_remote_ctl_in) begin
               // Remote control takes the level from across the link.
               st_nxt.pad_level = pin_nine_remote_level_in;
            end else begin
               st_nxt.pad_level = st_r.pin_cfg[P9_LEVEL_BIT];
            end
         end
         MODE_IN: begin
            st_nxt.pad_oe    = 1'b0;
            st_nxt.pad_level = 1'b0;
         end
         default: begin
            st_nxt.pad_oe    = 1'b0;
            st_nxt.pad_level = 1'b0;
         end
      endcase
   end

   // The only clocked process; reset loads constants only.
   // The asynchronous reset sets the pad outputs at once, even before
   // the clock runs.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r.alias7    <= RST_ALIAS7[ALIAS_MSB:ALIAS_LSB];
         st_r.box_a     <= RST_BOX_A;
         st_r.box_b     <= RST_BOX_B;
         st_r.pin_cfg   <= RST_PIN_CFG;
         st_r.rdata     <= '0;
         st_r.rmt_rdata <= '0;
         st_r.fwd_valid <= 1'b0;
         st_r.fwd_addr  <= '0;
         // Functional output mode after reset, driving low.
         st_r.pad_level <= 1'b0;
         st_r.pad_oe    <= 1'b1;
         st_r.pad_in    <= 1'b0;
         st_r.glb_level <= 1'b0;
         st_r.glb_oe    <= 1'b0;
         st_r.glb_in    <= 1'b0;
         st_r.glb_hiz   <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Every data output comes straight from a flip-flop.
   // A trade-off: a cycle of latency is spent so that paths outside
   // the block never run through it.
   // Outputs follow no input combinationally.
   assign rdata_out              = st_r.rdata;
   assign rmt_rdata_out          = st_r.rmt_rdata;
   assign fwd_valid_out          = st_r.fwd_valid;
   assign fwd_addr_out           = st_r.fwd_addr;
   assign remote_alias_seven_out = st_r.alias7;
   assign pin_nine_pad_out       = st_r.pad_level;
   assign pin_nine_pad_oe_out    = st_r.pad_oe;
   assign pin_nine_in_level_out  = st_r.pad_in;
   assign glb_force_level_out    = st_r.glb_level;
   assign glb_force_oe_out       = st_r.glb_oe;
   assign glb_force_in_out       = st_r.glb_in;
   assign glb_tristate_out       = st_r.glb_hiz;

endmodule // alias_mailbox_gpio_cfg_regs

// ---- testbench/cfg_regs_asserts.sv ----
// Watches the register ports, the alias decoder and the global flags.
module cfg_regs_checker
   import cfg_regs_pkg::*;
(
   input wire logic              clk_in,
   input wire logic              nrst_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   input wire logic              wr_in,
   input wire logic              rd_in,
   input wire logic [DATA_W-1:0] rdata_out,
   input wire logic              rmt_wr_in,
   input wire logic              rmt_rd_in,
   input wire logic [DATA_W-1:0] rmt_rdata_out,
   input wire logic [I2C_W-1:0]  i2c_addr_in,
   input wire logic              i2c_start_in,
   input wire logic [I2C_W-1:0]  remote_target_id_in,
   input wire logic              fwd_valid_out,
   input wire logic [I2C_W-1:0]  fwd_addr_out,
   input wire logic [I2C_W-1:0]  remote_alias_seven_out,
   input wire logic              glb_force_level_out,
   input wire logic              glb_force_oe_out,
   input wire logic              glb_force_in_out,
   input wire logic              glb_tristate_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain, so clock and reset are given once.
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   a_rdata_quiet: assert property (!rd_in |=> rdata_out == 8'h00)
      else $error("local read data not zero outside a read");
   a_rmt_quiet: assert property (!rmt_rd_in |=> rmt_rdata_out == 8'h00)
      else $error("remote read data not zero outside a read");
   a_box_echo: assert property (wr_in && addr_in == OFS_BOX_A ##1
      rd_in && addr_in == OFS_BOX_A && !rmt_wr_in
      |=> rdata_out == $past(wdata_in, 2))
      else $error("mailbox byte did not return the written value");
   a_alias_load: assert property (wr_in && addr_in == OFS_ALIAS7
      |=> remote_alias_seven_out == 7'($past(wdata_in) >> 1))
      else $error("alias field not loaded from bits 7 to 1");
   a_fwd_hit: assert property (i2c_start_in &&
      remote_alias_seven_out != 7'h00 &&
      i2c_addr_in == remote_alias_seven_out
      |=> fwd_valid_out && fwd_addr_out == $past(remote_target_id_in))
      else $error("alias match not forwarded with target id");
   a_fwd_miss: assert property (!(i2c_start_in &&
      remote_alias_seven_out != 7'h00 &&
      i2c_addr_in == remote_alias_seven_out) |=> !fwd_valid_out)
      else $error("forward pulse without a live alias match");
   a_fwd_hold: assert property (!fwd_valid_out |-> $stable(fwd_addr_out))
      else $error("forward address moved without a pulse");
   a_cfg_resv: assert property (rd_in && addr_in == OFS_PIN_CFG
      |=> rdata_out[6] == 1'b0 && rdata_out[2] == 1'b0)
      else $error("reserved configuration bits read non zero");
   a_glb_excl: assert property ($onehot0({glb_force_oe_out,
      glb_force_in_out, glb_tristate_out}))
      else $error("more than one global pad mode active");
   a_glb_level: assert property (glb_force_level_out |-> glb_force_oe_out)
      else $error("global level shown outside forced output");
endmodule // cfg_regs_checker

bind alias_mailbox_gpio_cfg_regs cfg_regs_checker cfg_regs_checker_i (
   .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .rmt_wr_in(rmt_wr_in), .rmt_rd_in(rmt_rd_in),
   .rmt_rdata_out(rmt_rdata_out), .i2c_addr_in(i2c_addr_in),
   .i2c_start_in(i2c_start_in), .remote_target_id_in(remote_target_id_in),
   .fwd_valid_out(fwd_valid_out), .fwd_addr_out(fwd_addr_out),
   .remote_alias_seven_out(remote_alias_seven_out),
   .glb_force_level_out(glb_force_level_out),
   .glb_force_oe_out(glb_force_oe_out), .glb_force_in_out(glb_force_in_out),
   .glb_tristate_out(glb_tristate_out));

// ---- testbench/remote_ctl_model.sv ----
// Controller at the far end of the link, using the remote register port.
module remote_ctl_model
   import cfg_regs_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic [DATA_W-1:0] rmt_rdata_in,
   output logic      [ADDR_W-1:0] rmt_addr_out,
   output logic      [DATA_W-1:0] rmt_wdata_out,
   output logic                   rmt_wr_out,
   output logic                   rmt_rd_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle port at time zero.
   initial begin
      rmt_addr_out = 8'h00;
      rmt_wdata_out = 8'h00;
      rmt_wr_out = 1'b0;
      rmt_rd_out = 1'b0;
   end

   // One write; released lines flip so stale values never look valid.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      rmt_addr_out <= a;
      rmt_wdata_out <= d;
      rmt_wr_out <= 1'b1;
      @(posedge clk_in);
      rmt_wr_out <= 1'b0;
      rmt_addr_out <= ~a;
      rmt_wdata_out <= ~d;
   endtask

   // One read; the data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge clk_in);
      rmt_addr_out <= a;
      rmt_rd_out <= 1'b1;
      @(posedge clk_in);
      rmt_rd_out <= 1'b0;
      rmt_addr_out <= ~a;
      #1 q = rmt_rdata_in;
   endtask
endmodule // remote_ctl_model

// ---- testbench/alias_mailbox_gpio_cfg_regs_test.sv ----
// Self-checking bench for the alias, mailbox and pin configuration bank.
module alias_mailbox_gpio_cfg_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cfg_regs_pkg::*;

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   err_count++; $display("mismatch %s expected %h seen %h", n, e, g); \
   end end

   // A row: offset, written value, read back, {oe, level}, global flags.
   typedef struct packed {
      logic [7:0] a, d, r;
      logic [1:0] pad;
      logic [3:0] glb;
   } row_t;
   localparam row_t ROWS [12] = '{
      '{8'h17, 8'hFF, 8'hFE, 2'h3, 4'h0}, '{8'h18, 8'hA5, 8'hA5, 2'h3, 4'h0},
      '{8'h19, 8'h3C, 8'h3C, 2'h3, 4'h0}, '{8'h20, 8'h77, 8'h00, 2'h3, 4'h0},
      '{8'h1A, 8'hFF, 8'hBB, 2'h0, 4'h2}, '{8'h1A, 8'h09, 8'h09, 2'h3, 4'h0},
      '{8'h1A, 8'h01, 8'h01, 2'h2, 4'h0}, '{8'h1A, 8'h02, 8'h02, 2'h0, 4'h0},
      '{8'h1A, 8'h90, 8'h90, 2'h3, 4'hC}, '{8'h1A, 8'h11, 8'h11, 2'h2, 4'h4},
      '{8'h1A, 8'h20, 8'h20, 2'h0, 4'h1}, '{8'h1A, 8'h00, 8'h00, 2'h3, 4'h0}};
   // Reset values of the four registers, offsets 0x17 to 0x1A.
   localparam logic [7:0] RSTV [4] = '{8'h00, 8'h00, 8'h01, 8'h00};

   logic       clk_in, nrst_in, wr_in, rd_in, i2c_start_in;
   logic [7:0] addr_in, wdata_in, rdata_out, rmt_rdata_out, q;
   logic [7:0] rmt_addr_in, rmt_wdata_in;
   logic       rmt_wr_in, rmt_rd_in, fwd_valid_out;
   logic [6:0] i2c_addr_in, remote_target_id_in, fwd_addr_out, alias_q;
   logic       pad_in, func_lvl, rem_ctl, rem_lvl, pad_out, pad_oe, in_lvl;
   logic       g_lvl, g_oe, g_in, g_tri;
   int         err_count = 0;
   int         compares = 0;
   int         cycles = 0;

   alias_mailbox_gpio_cfg_regs alias_mailbox_gpio_cfg_regs_i (
      .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .rmt_addr_in(rmt_addr_in),
      .rmt_wdata_in(rmt_wdata_in), .rmt_wr_in(rmt_wr_in),
      .rmt_rd_in(rmt_rd_in), .rmt_rdata_out(rmt_rdata_out),
      .i2c_addr_in(i2c_addr_in), .i2c_start_in(i2c_start_in),
      .remote_target_id_in(remote_target_id_in),
      .fwd_valid_out(fwd_valid_out), .fwd_addr_out(fwd_addr_out),
      .remote_alias_seven_out(alias_q), .pin_nine_pad_in(pad_in),
      .pin_nine_func_level_in(func_lvl), .pin_nine_remote_ctl_in(rem_ctl),
      .pin_nine_remote_level_in(rem_lvl), .pin_nine_pad_out(pad_out),
      .pin_nine_pad_oe_out(pad_oe), .pin_nine_in_level_out(in_lvl),
      .glb_force_level_out(g_lvl), .glb_force_oe_out(g_oe),
      .glb_force_in_out(g_in), .glb_tristate_out(g_tri));

   remote_ctl_model remote_ctl_model_i (
      .clk_in(clk_in), .rmt_rdata_in(rmt_rdata_out),
      .rmt_addr_out(rmt_addr_in), .rmt_wdata_out(rmt_wdata_in),
      .rmt_wr_out(rmt_wr_in), .rmt_rd_out(rmt_rd_in));

   // Free-running 8 ns clock.
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   // Cuts a hang short; the whole run needs well under a thousand cycles.
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Local register write, one strobe cycle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   // Local register read; data are taken in the one cycle they stand.
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
   endtask

   // One I2C start; a hit must pulse once with the target id.
   task automatic hit(input logic [6:0] a, input logic [6:0] id,
                      input logic ev);
      @(posedge clk_in);
      i2c_addr_in <= a;
      remote_target_id_in <= id;
      i2c_start_in <= 1'b1;
      @(posedge clk_in);
      i2c_start_in <= 1'b0;
      #1 `CHK("forward pulse", ev, fwd_valid_out)
      if (ev) `CHK("forward address", id, fwd_addr_out)
   endtask

   initial begin
      {nrst_in, wr_in, rd_in, i2c_start_in, pad_in, rem_ctl, rem_lvl} = '0;
      {addr_in, wdata_in, i2c_addr_in, remote_target_id_in} = '0;
      func_lvl = 1'b1;
      repeat (5) @(posedge clk_in);
      nrst_in <= 1'b1;
      // Ordinary register and pin configuration cases.
      foreach (ROWS[i]) begin
         wr(ROWS[i].a, ROWS[i].d);
         rd(ROWS[i].a, q);
         `CHK("read back", ROWS[i].r, q)
         `CHK("pin nine", ROWS[i].pad, {pad_oe, pad_oe & pad_out})
         `CHK("global", ROWS[i].glb, {g_lvl, g_oe, g_in, g_tri})
      end
      // Mailboxes carry bytes across the link in both directions.
      remote_ctl_model_i.wr(OFS_BOX_A, 8'hC3);
      rd(OFS_BOX_A, q);
      `CHK("remote to local", 8'hC3, q)
      wr(OFS_BOX_B, 8'h96);
      remote_ctl_model_i.rd(OFS_BOX_B, q);
      `CHK("local to remote", 8'h96, q)
      // Write then read with no idle cycle between the strobes.
      @(posedge clk_in);
      addr_in <= OFS_BOX_A;
      wdata_in <= 8'h5A;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 `CHK("write then read", 8'h5A, rdata_out)
      // Alias decoding: hit, miss, then a cleared slot.
      wr(OFS_ALIAS7, 8'h84);
      #1 `CHK("alias field", 7'h42, alias_q)
      hit(7'h42, 7'h11, 1'b1);
      hit(7'h43, 7'h11, 1'b0);
      wr(OFS_ALIAS7, 8'h01);
      hit(7'h00, 7'h33, 1'b0);
      // Remote control takes pin nine away from the local level bit.
      wr(OFS_PIN_CFG, 8'h09);
      rem_ctl <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1 `CHK("remote level low", 1'b0, pad_out)
      @(posedge clk_in);
      rem_lvl <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1 `CHK("remote level high", 1'b1, pad_out)
      @(posedge clk_in);
      pad_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1 `CHK("pad input level", 1'b1, in_lvl)
      // Reset in mid-run restores every register.
      @(posedge clk_in);
      nrst_in <= 1'b0;
      func_lvl <= 1'b0;
      repeat (5) @(posedge clk_in);
      nrst_in <= 1'b1;
      foreach (RSTV[i]) begin
         rd(OFS_ALIAS7 + 8'(i), q);
         `CHK("reset value", RSTV[i], q)
      end
      `CHK("functional output", 2'h2, {pad_oe, pad_out})
      tally_and_finish();
   end
endmodule // alias_mailbox_gpio_cfg_regs_test
